// ===== hw/brp_edge_if.sv
// synchronised pin level with its edge pulses
interface brp_edge_if #(parameter int W = 1);
  logic [W-1:0] lvl; // synchronised level
  logic rise; // one-cycle pulse on a rising bit 0
  logic fall; // one-cycle pulse on a falling bit 0
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : brp_edge_if

// ===== hw/brp_map.svh
// constants of the byte-wide result port: field positions, counts and times
`ifndef BRP_MAP_SVH
`define BRP_MAP_SVH
`define BRP_SYS_PERIOD_NS 40
`define BRP_RES_W 12
`define BRP_BYTE_W 8
`define BRP_NIB_LSB 8
`define BRP_NIB_MSB 11
`define BRP_CFG_ACQ_BIT 5
`define BRP_CONV_CLKS 13
`define BRP_ACQ_CLKS 3
`define BRP_INT_DIV_CYC 6
`define BRP_CNT_W 4
`define BRP_DIV_W 3
`define BRP_RD_HIZ_MIN_NS 20
`define BRP_RD_HIZ_MAX_NS 70
`define BRP_CS_HIZ_MIN_NS 20
`define BRP_CS_HIZ_MAX_NS 100
`define BRP_RD_VALID_MAX_NS 70
`define BRP_SEL_VALID_MAX_NS 110
`define BRP_INT_CLR_MAX_NS 100
`define BRP_RD_HIZ_MIN_CYC ((`BRP_RD_HIZ_MIN_NS + `BRP_SYS_PERIOD_NS - 1) / `BRP_SYS_PERIOD_NS)
`define BRP_CS_HIZ_MAX_CYC (`BRP_CS_HIZ_MAX_NS / `BRP_SYS_PERIOD_NS)
`define BRP_INT_CLR_CYC (`BRP_INT_CLR_MAX_NS / `BRP_SYS_PERIOD_NS)
`define BRP_SEL_VALID_CYC (`BRP_SEL_VALID_MAX_NS / `BRP_SYS_PERIOD_NS)
`define BRP_ZERO_NIB 4'h0
`define BRP_ZERO_CFG 8'h00
`define BRP_ZERO_RES 12'h000
`endif

// ===== hw/brp_pkg.sv
// types shared by the byte-wide result port
package brp_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {
    brp_idle,
    brp_acq,
    brp_conv
  } brp_state_t;
endpackage : brp_pkg

// ===== hw/brp_port.sv
// byte-wide parallel result port of a 12-bit converter
// How it works
// - select high gives top nibble, else low byte
// - low four lines shared between both bytes
// - read fall raises done flag within 100 ns
// - read rise releases bus 20 to 70 ns
// - select rise releases bus 20 to 100 ns
// - data valid after read fall or byte change
// - conversion length counted in converter clock cycles
// - done flag goes low when result ready
// - write rise latches config and starts sequence
// - read fall with select low drives bus
`include "brp_map.svh"
module brp_port (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic cs_n, // chip select pin, active low
  input wire logic rd_n, // read strobe pin, active low
  input wire logic wr_n, // write strobe pin, active low
  input wire logic result_byte_select, // 1 selects top nibble
  input wire logic conv_clk, // external converter clock pin
  input wire logic ext_clk_mode, // 1 counts conv_clk, 0 internal divider
  input wire logic [7:0] data_in, // data lines as seen by the device
  input wire logic [11:0] core_result, // result from the converter core
  output logic [7:0] data_out, // data lines driven by the device
  output logic data_oe, // high while the device drives the lines
  output logic conv_done_n, // conversion complete, active low
  output logic [7:0] cfg_byte // last configuration byte latched
);
  // synchronised pins
  brp_edge_if #(.W(1)) cs_s ();
  brp_edge_if #(.W(1)) rd_s ();
  brp_edge_if #(.W(1)) wr_s ();
  brp_edge_if #(.W(1)) sel_s ();
  brp_edge_if #(.W(1)) cclk_s ();
  brp_edge_if #(.W(1)) mode_s ();
  brp_edge_if #(.W(8)) din_s ();

  brp_sync #(.W(1), .INIT(1'b1)) u_cs (.sys_clk(sys_clk), .srst(srst), .pin(cs_n), .sync(cs_s));
  brp_sync #(.W(1), .INIT(1'b1)) u_rd (.sys_clk(sys_clk), .srst(srst), .pin(rd_n), .sync(rd_s));
  brp_sync #(.W(1), .INIT(1'b1)) u_wr (.sys_clk(sys_clk), .srst(srst), .pin(wr_n), .sync(wr_s));
  brp_sync #(.W(1), .INIT(1'b0)) u_sel (.sys_clk(sys_clk), .srst(srst),
    .pin(result_byte_select), .sync(sel_s));
  brp_sync #(.W(1), .INIT(1'b0)) u_cclk (.sys_clk(sys_clk), .srst(srst),
    .pin(conv_clk), .sync(cclk_s));
  brp_sync #(.W(1), .INIT(1'b0)) u_mode (.sys_clk(sys_clk), .srst(srst),
    .pin(ext_clk_mode), .sync(mode_s));
  brp_sync #(.W(8), .INIT(8'h00)) u_din (.sys_clk(sys_clk), .srst(srst),
    .pin(data_in), .sync(din_s));

  brp_pkg::brp_state_t state; // sequencer state
  logic [`BRP_CNT_W-1:0] tick_cnt; // converter clocks counted in a phase
  logic [`BRP_DIV_W-1:0] div_cnt; // internal converter clock divider
  logic conv_tick; // one converter clock falling edge
  logic [11:0] result_q; // latched conversion result
  logic wr_start; // qualified write rising edge
  logic rd_start; // qualified read falling edge
  logic conv_end; // last converter clock of conversion
  logic ext_acq; // configuration asks for external acquisition

  assign wr_start = wr_s.rise & ~cs_s.lvl[0];
  assign rd_start = rd_s.fall & ~cs_s.lvl[0];
  assign ext_acq = cfg_byte[`BRP_CFG_ACQ_BIT];
  assign conv_end = (state == brp_pkg::brp_conv) & conv_tick &
    (tick_cnt == `BRP_CNT_W'(`BRP_CONV_CLKS - 1));

  // internal converter clock: divide the system clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_cnt <= '0;
    end else if (div_cnt == `BRP_DIV_W'(`BRP_INT_DIV_CYC - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + `BRP_DIV_W'(1);
    end
  end

  // converter clock edge from the pin or from the divider
  assign conv_tick = mode_s.lvl[0] ? cclk_s.fall :
    (div_cnt == `BRP_DIV_W'(`BRP_INT_DIV_CYC - 1));

  // configuration byte latch on a write rising edge when idle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_byte <= `BRP_ZERO_CFG;
    end else if (wr_start && state == brp_pkg::brp_idle) begin
      cfg_byte <= din_s.lvl;
    end
  end

  // sequencer: acquisition then conversion, counted in converter clocks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= brp_pkg::brp_idle;
      tick_cnt <= '0;
    end else begin
      case (state)
        brp_pkg::brp_idle: begin
          tick_cnt <= '0;
          if (wr_start) begin
            // external acquisition: this edge ends acquisition
            if (din_s.lvl[`BRP_CFG_ACQ_BIT]) begin
              state <= brp_pkg::brp_conv;
            end else begin
              state <= brp_pkg::brp_acq;
            end
          end
        end
        brp_pkg::brp_acq: begin
          // write edges are ignored while busy; host holds it high
          if (conv_tick) begin
            if (tick_cnt == `BRP_CNT_W'(`BRP_ACQ_CLKS - 1)) begin
              tick_cnt <= '0;
              state <= brp_pkg::brp_conv;
            end else begin
              tick_cnt <= tick_cnt + `BRP_CNT_W'(1);
            end
          end
        end
        brp_pkg::brp_conv: begin
          if (conv_end) begin
            tick_cnt <= '0;
            state <= brp_pkg::brp_idle;
          end else if (conv_tick) begin
            tick_cnt <= tick_cnt + `BRP_CNT_W'(1);
          end
        end
        default: begin
          state <= brp_pkg::brp_idle;
          tick_cnt <= '0;
        end
      endcase
    end
  end

  // result latch at the end of conversion
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_q <= `BRP_ZERO_RES;
    end else if (conv_end) begin
      result_q <= core_result;
    end
  end

  // done flag: set by conversion end, cleared by a read; set wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_done_n <= 1'b1;
    end else if (conv_end) begin
      conv_done_n <= 1'b0;
    end else if (rd_start) begin
      conv_done_n <= 1'b1;
    end
  end

  // byte mux: low byte, or top nibble on the shared low lines with upper lines zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_out <= 8'h00;
    end else if (sel_s.lvl[0]) begin
      data_out <= {`BRP_ZERO_NIB, result_q[`BRP_NIB_MSB:`BRP_NIB_LSB]};
    end else begin
      data_out <= result_q[`BRP_BYTE_W-1:0];
    end
  end

  // bus drive while select and read are both low; one cycle release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= ~cs_s.lvl[0] & ~rd_s.lvl[0];
    end
  end

  // checks
  default clocking brp_cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  localparam int RD_HIZ_MIN = `BRP_RD_HIZ_MIN_CYC;
  localparam int CS_HIZ_MAX = `BRP_CS_HIZ_MAX_CYC;
  localparam int INT_CLR_MAX = `BRP_INT_CLR_CYC;

  a_rd_release: assert property ($rose(rd_s.lvl[0]) |-> ##RD_HIZ_MIN !data_oe)
    else $error("bus not released after read rise");
  // the drive at a read rise was launched by the levels one edge earlier
  a_rd_hold: assert property ($rose(rd_s.lvl[0]) && $past(!cs_s.lvl[0]) |-> data_oe)
    else $error("bus released too early after read rise");
  a_cs_release: assert property ($rose(cs_s.lvl[0]) |-> ##[RD_HIZ_MIN:CS_HIZ_MAX] !data_oe)
    else $error("bus not released after select rise");
  a_read_drive: assert property (rd_start |=> data_oe)
    else $error("read start did not drive the bus");
  a_done_clear: assert property (rd_start && !conv_end |-> ##[1:INT_CLR_MAX] conv_done_n)
    else $error("done flag not cleared by read");
  a_done_set: assert property (conv_end |=> !conv_done_n && state == brp_pkg::brp_idle)
    else $error("done flag not set at conversion end");
  a_high_nibble: assert property ($past(sel_s.lvl[0]) |->
    data_out == {`BRP_ZERO_NIB, $past(result_q[`BRP_NIB_MSB:`BRP_NIB_LSB])})
    else $error("high nibble wrong");
  a_low_byte: assert property (!$past(sel_s.lvl[0]) |->
    data_out == $past(result_q[`BRP_BYTE_W-1:0]))
    else $error("low byte wrong");
  a_conv_count: assert property (state == brp_pkg::brp_conv |->
    tick_cnt < `BRP_CNT_W'(`BRP_CONV_CLKS))
    else $error("conversion counter overran");
  a_wr_start: assert property (wr_start && state == brp_pkg::brp_idle |=>
    state != brp_pkg::brp_idle && cfg_byte == $past(din_s.lvl))
    else $error("write did not start a sequence");

  c_int_acq: cover property (state == brp_pkg::brp_acq ##[1:200] conv_end);
  c_ext_acq: cover property (wr_start && ext_acq);
  c_read_high: cover property (rd_start ##[1:20] sel_s.lvl[0] && data_oe);
  c_cs_release: cover property ($rose(cs_s.lvl[0]) && data_oe);
endmodule : brp_port

// ===== hw/brp_sync.sv
// two-flop synchroniser with edge detection on bit 0
module brp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [W-1:0] pin, // raw asynchronous pin
  brp_edge_if.src sync // synchronised level and edges
);
  logic [W-1:0] meta; // first stage, read only by the second
  logic [W-1:0] stage; // second stage, safe to use
  logic prev; // previous safe value of bit 0

  // double flop then one more delay for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta <= INIT;
      stage <= INIT;
      prev <= INIT[0];
    end else begin
      meta <= pin;
      stage <= meta;
      prev <= stage[0];
    end
  end

  assign sync.lvl = stage;
  assign sync.rise = stage[0] & ~prev;
  assign sync.fall = ~stage[0] & prev;
endmodule : brp_sync

// ===== tb/brp_host.sv
// host processor model driving the parallel port pins
module brp_host (
  input wire logic sys_clk, // system clock
  input wire logic data_oe, // device drives the lines
  input wire logic [7:0] data_out, // device output byte
  output logic cs_n, // chip select, active low
  output logic rd_n, // read strobe, active low
  output logic wr_n, // write strobe, active low
  output logic result_byte_select, // 1 picks top nibble
  output logic [7:0] data_in // resolved data lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bus; // byte the host places on the lines
  logic drv; // host drives the lines
  // released lines show the inverse of the last byte
  assign data_in = data_oe ? data_out : (drv ? bus : ~bus);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    result_byte_select = 1'b0;
    bus = 8'h00;
    drv = 1'b0;
  end
  // step n edges, then the fixed drive delay
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc
  // one configuration write; data held past the rise
  task automatic write_cfg(input logic [7:0] b);
    cs_n = 1'b0;
    bus = b;
    drv = 1'b1;
    cyc(2);
    wr_n = 1'b0;
    cyc(2);
    wr_n = 1'b1; // stays high well past the first converter edge
    cyc(4);
    drv = 1'b0;
    cs_n = 1'b1;
  endtask : write_cfg
  // open a read cycle; cs optionally left high
  task automatic read_start(input logic sel, input logic sel_cs);
    cs_n = ~sel_cs;
    result_byte_select = sel;
    rd_n = 1'b0;
  endtask : read_start
  // set chip select, read strobe and byte select together
  task automatic drive(input logic c, input logic r, input logic s);
    cs_n = c;
    rd_n = r;
    result_byte_select = s;
  endtask : drive
endmodule : brp_host

// ===== tb/byte_wide_result_port_test.sv
// self-checking bench of the byte-wide result port
module byte_wide_result_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, conv_clk, ext_clk_mode; // clock, reset, converter clock pins
  logic cs_n, rd_n, wr_n, result_byte_select; // host strobes
  logic [7:0] data_in, data_out, cfg_byte; // bytes
  logic [11:0] core_result, res; // core result and its copy
  logic data_oe, conv_done_n, prev_oe; // outputs and monitor state
  logic [7:0] cfg; // configuration byte under test
  logic sel; // byte select of the first byte of a read
  logic [7:0] exp_q[$]; // expected first bytes of reads
  int mismatches, compares; // counters
  brp_port brp_port_i (.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .result_byte_select(result_byte_select), .conv_clk(conv_clk), .ext_clk_mode(ext_clk_mode),
    .data_in(data_in), .core_result(core_result), .data_out(data_out), .data_oe(data_oe),
    .conv_done_n(conv_done_n), .cfg_byte(cfg_byte));
  brp_host brp_host_i (.sys_clk(sys_clk), .data_oe(data_oe), .data_out(data_out), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .result_byte_select(result_byte_select), .data_in(data_in));
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // print counts and verdict, then stop
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // bounded wait for the done flag to fall
  task automatic wait_done;
    int k;
    for (k = 0; k < 500 && conv_done_n !== 1'b0; k++) brp_host_i.cyc(1);
    if (conv_done_n !== 1'b0) begin
      mismatches++;
      $display("FAIL %0t no conversion end", $time);
      give_verdict();
    end
  endtask : wait_done
  // monitor: first byte of each read against the oldest note
  always @(posedge sys_clk) begin
    if (data_oe === 1'b1 && prev_oe !== 1'b1) begin
      if (exp_q.size() == 0) check(data_out, 12'hfff); // drive without a read
      else check(data_out, exp_q.pop_front()); // selected byte on the bus
    end
    prev_oe <= data_oe;
  end
  // main sequence
  initial begin
    srst = 1'b1;
    conv_clk = 1'b0;
    ext_clk_mode = 1'b0;
    core_result = 12'h000;
    mismatches = 0;
    compares = 0;
    void'($urandom(32));
    repeat (16) @(posedge sys_clk);
    #2;
    srst = 1'b0;
    check({data_oe, conv_done_n, cfg_byte}, 12'h100); // reset levels
    // internal acquisition: write, convert, read both bytes in random order
    for (int i = 0; i < 3; i++) begin
      res = 12'($urandom);
      cfg = 8'($urandom) & 8'hdf;
      sel = 1'($urandom);
      conv_clk = 1'($urandom); // ignored while the internal divider runs
      core_result = res;
      brp_host_i.write_cfg(cfg);
      wait_done();
      check(cfg_byte, cfg);
      exp_q.push_back(sel ? {4'h0, res[11:8]} : res[7:0]);
      brp_host_i.read_start(sel, 1'b1);
      brp_host_i.cyc(4);
      check(conv_done_n, 1'b1);
      brp_host_i.drive(1'b0, 1'b0, ~sel);
      brp_host_i.cyc(3);
      check(data_out, sel ? res[7:0] : {4'h0, res[11:8]});
      brp_host_i.drive(1'b0, 1'b1, ~sel);
      brp_host_i.cyc(1);
      check(data_oe, 1'b1);
      brp_host_i.cyc(2);
      check(data_oe, 1'b0);
      brp_host_i.drive(1'b1, 1'b1, ~sel);
      brp_host_i.cyc(1);
      $display("test %0d done", i);
    end
    // read with chip select high, then chip select ending a read
    cfg = 8'($urandom) & 8'hdf;
    brp_host_i.write_cfg(cfg);
    wait_done();
    check(cfg_byte, cfg);
    brp_host_i.read_start(1'b0, 1'b0);
    brp_host_i.cyc(6);
    check({data_oe, conv_done_n}, 12'h000);
    exp_q.push_back(res[7:0]);
    brp_host_i.drive(1'b0, 1'b0, 1'b0);
    brp_host_i.cyc(4);
    brp_host_i.drive(1'b1, 1'b0, 1'b0);
    brp_host_i.cyc(1);
    check(data_oe, 1'b1);
    brp_host_i.cyc(2);
    check(data_oe, 1'b0);
    check(conv_done_n, 1'b0); // no read fall while selected, flag kept
    brp_host_i.drive(1'b1, 1'b1, 1'b0);
    brp_host_i.cyc(1);
    // a proper read clears the flag before the next conversion
    sel = 1'($urandom);
    exp_q.push_back(sel ? {4'h0, res[11:8]} : res[7:0]);
    brp_host_i.read_start(sel, 1'b1);
    brp_host_i.cyc(4);
    check(conv_done_n, 1'b1);
    brp_host_i.drive(1'b1, 1'b1, sel);
    brp_host_i.cyc(3);
    check(data_oe, 1'b0);
    $display("test cs done");
    // external clock, external acquisition: 13 converter ticks
    conv_clk = 1'b0;
    ext_clk_mode = 1'b1;
    res = 12'($urandom);
    core_result = res;
    cfg = 8'($urandom) | 8'h20;
    brp_host_i.write_cfg(cfg);
    check(cfg_byte, cfg);
    for (int t = 0; t < 13; t++) begin
      if (t == 12) check(conv_done_n, 1'b1);
      conv_clk = 1'b1;
      brp_host_i.cyc(3);
      conv_clk = 1'b0;
      brp_host_i.cyc(8);
    end
    check(conv_done_n, 1'b0);
    sel = 1'($urandom);
    exp_q.push_back(sel ? {4'h0, res[11:8]} : res[7:0]);
    brp_host_i.read_start(sel, 1'b1);
    brp_host_i.cyc(4);
    check(conv_done_n, 1'b1);
    brp_host_i.drive(1'b1, 1'b1, sel);
    brp_host_i.cyc(3);
    check(12'(exp_q.size()), 12'h000); // every noted read was seen
    $display("test ext done");
    give_verdict();
  end
endmodule : byte_wide_result_port_test
